// File: tw_decode.sv
// Decoder/executor for table write, skip, exclusive-OR and extended instructions
// What this block does
// - Table write copies table latch into holding register picked by pointer bits 2:0
// - Table write mode: 0 keep, 1 post-increment, 2 post-decrement, 3 pre-increment
// - Table pointer is a 21-bit byte address; steps use the full width
// - Pointer bit 0 picks low (0) or high (1) byte of a program word
// - Test-skip reads the file register picked by operand and access bit, skips if zero, flags untouched
// - Skipped instruction is discarded as a no-op: one cycle, two on skip
// - Skipping a two-word instruction discards both words: three cycles
// - Access bit 0 selects access bank, 1 uses bank select plus operand
// - Access bit 0, extension on, operand up to 95: indexed literal offset
// - Literal exclusive-OR into accumulator, negative and zero flags, one cycle
// - Register exclusive-OR with accumulator, negative and zero flags, one cycle
// - Direction 0 writes accumulator, 1 writes back to the file register
// - Extension disabled by default; enabled only by the configuration bit
// - Pointer select 11 adds to third pointer then returns, two cycles
// - Subtract-from-pointer likewise; select 11 subtracts then returns in two cycles
// - Opcode 0014h is a two-cycle call with low target byte from accumulator
// - That call pushes own address plus two and loads high bytes from latches
// - Indexed moves take their source address from third pointer plus the 7-bit offset
// - Push literal stores at third pointer address then decrements it, one cycle
// - Add-to-pointer literal is unsigned 6-bit added to full pointer
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/1ps
module tw_decode
   import tw_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic extension_enable_bit,
   input wire logic ins_valid,
   input wire logic [15:0] ins_word,
   input wire logic [TP_W-1:0] ins_pc,
   output logic ins_ready_q,
   output logic stk_push_q,
   output logic [TP_W-1:0] stk_data_q,
   output logic pc_load_q,
   output logic [TP_W-1:0] pc_value_q,
   output logic ret_q,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_we,
   input wire logic reg_re,
   output logic [7:0] reg_rdata_q
);
   typedef enum logic [3:0] {
      S_RUN = 4'b0001,
      S_TBL2 = 4'b0010,
      S_RET2 = 4'b0100,
      S_MOV2 = 4'b1000
   } tw_state_t;

   function automatic logic hit(input logic [15:0] w, input logic [15:0] m,
                                input logic [15:0] v);
      hit = (w & m) == v;
   endfunction

   function automatic logic two_word(input logic [15:0] w, input logic ext);
      two_word = hit(w, M_CALL2, V_CALL2) || hit(w, M_LFSR2, V_LFSR2) ||
                 hit(w, M_BYTE8, V_GOTO2) || hit(w, M_NIB, V_MOVFF2) ||
                 (ext && hit(w, M_BYTE8 & M_MOVS, V_INDEXED_TO_FILE_MOVE_OP));
   endfunction

   function automatic logic [DA_W-1:0] file_addr(input logic [7:0] f, input logic a,
                                                  input logic [7:0] bank_select_register,
                                                  input logic [DA_W-1:0] third_pointer,
                                                  input logic ext);
      if (a) begin
         file_addr = {bank_select_register[3:0], f};
      end else if (ext && f <= IDX_LIMIT) begin
         file_addr = third_pointer + {4'h0, f};
      end else if (f >= ACC_SPLIT) begin
         file_addr = {ACC_HI_BANK, f};
      end else begin
         file_addr = {4'h0, f};
      end
   endfunction

   tw_state_t state_q, state_d;
   logic ext_q, skip_q;
   logic [7:0] acc_q, status_q, bsr_q, tlatch_q, pc_high_latch_q, pc_upper_latch_q;
   logic [TP_W-1:0] tp_q;
   logic [1:0] tmode_q;
   logic [DA_W-1:0] fsr_q [0:2];
   logic [6:0] zs_q;
   logic [DA_W-1:0] dm_addr_q;
   logic indexed_to_indexed_move_op_q;

   logic take, exec_run, exec_mov;
   logic op_table_write_op, op_tst, op_literal_exclusive_or_op, op_register_exclusive_or_op, op_addp, op_subp;
   logic op_push_literal_op, op_indexed_to_file_move_op, op_indexed_to_indexed_move_op, op_accumulator_call_op, op_ptr_ret;
   logic [1:0] psel;
   logic [DA_W-1:0] fa, core_raddr, mov_src, mem_waddr;
   logic [7:0] mrd, bus_mrd, hold_rd, xor_res, mem_wdata;
   logic mem_we, core_we, hold_we;
   logic [TP_W-1:0] tp_next;

   assign take = ins_valid && ins_ready_q;
   assign exec_run = take && state_q == S_RUN && !skip_q;
   assign exec_mov = take && state_q == S_MOV2;

   assign op_table_write_op = hit(ins_word, M_TABLE_WRITE_OP, V_TABLE_WRITE_OP);
   assign op_tst = hit(ins_word, M_TST, V_TST);
   assign op_literal_exclusive_or_op = hit(ins_word, M_LITERAL_EXCLUSIVE_OR_OP, V_LITERAL_EXCLUSIVE_OR_OP);
   assign op_register_exclusive_or_op = hit(ins_word, M_REGISTER_EXCLUSIVE_OR_OP, V_REGISTER_EXCLUSIVE_OR_OP);
   assign op_addp = ext_q && hit(ins_word, M_BYTE8, V_ADDP);
   assign op_subp = ext_q && hit(ins_word, M_BYTE8, V_SUBP);
   assign op_push_literal_op = ext_q && hit(ins_word, M_BYTE8, V_PUSH_LITERAL_OP);
   assign op_indexed_to_file_move_op = ext_q && hit(ins_word, M_MOVS, V_INDEXED_TO_FILE_MOVE_OP);
   assign op_indexed_to_indexed_move_op = ext_q && hit(ins_word, M_MOVS, V_INDEXED_TO_INDEXED_MOVE_OP);
   assign op_accumulator_call_op = ext_q && hit(ins_word, M_FULL, V_ACCUMULATOR_CALL_OP);
   assign psel = ins_word[7:6];
   assign op_ptr_ret = (op_addp || op_subp) && psel == PSEL_RET;

   assign fa = file_addr(ins_word[7:0], ins_word[8], bsr_q, fsr_q[2], ext_q);
   assign mov_src = fsr_q[2] + {5'h00, zs_q};
   assign core_raddr = (state_q == S_MOV2) ? mov_src : fa;
   assign xor_res = acc_q ^ (op_literal_exclusive_or_op ? ins_word[7:0] : mrd);

   always_comb begin
      core_we = 1'b0;
      mem_waddr = fa;
      mem_wdata = xor_res;
      if (exec_run && op_register_exclusive_or_op && ins_word[9]) begin
         core_we = 1'b1;
      end else if (exec_run && op_push_literal_op) begin
         core_we = 1'b1;
         mem_waddr = fsr_q[2];
         mem_wdata = ins_word[7:0];
      end else if (exec_mov) begin
         core_we = 1'b1;
         mem_wdata = mrd;
         if (!indexed_to_indexed_move_op_q) begin
            mem_waddr = ins_word[DA_W-1:0];
         end else begin
            mem_waddr = fsr_q[2] + {5'h00, ins_word[6:0]};
         end
      end
   end

   assign mem_we = core_we || (reg_we && reg_addr == R_DM_DATA);

   tw_data_mem u_mem (
      .clk(clk),
      .we(mem_we),
      .waddr(core_we ? mem_waddr : dm_addr_q),
      .wdata(core_we ? mem_wdata : reg_wdata),
      .raddr_a(core_raddr),
      .rdata_a(mrd),
      .raddr_b(dm_addr_q),
      .rdata_b(bus_mrd)
   );

   assign hold_we = state_q == S_TBL2;
   tw_hold_regs #(.N(HOLD_N)) u_hold (
      .clk(clk),
      .rst(rst),
      .we(hold_we),
      .widx(tp_q[2:0]),
      .wdata(tlatch_q),
      .ridx(reg_addr[2:0]),
      .rdata(hold_rd)
   );

   // Configuration bit caught while reset is held
   always_ff @(posedge clk) begin
      if (rst) begin
         ext_q <= extension_enable_bit;
      end
   end

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         S_RUN: begin
            if (exec_run && op_table_write_op) begin
               state_d = S_TBL2;
            end else if (exec_run && (op_ptr_ret || op_accumulator_call_op)) begin
               state_d = S_RET2;
            end else if (exec_run && (op_indexed_to_file_move_op || op_indexed_to_indexed_move_op)) begin
               state_d = S_MOV2;
            end
         end
         S_TBL2: state_d = S_RUN;
         S_RET2: state_d = S_RUN;
         S_MOV2: begin
            if (take) begin
               state_d = S_RUN;
            end
         end
         default: state_d = S_RUN;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= S_RUN;
         ins_ready_q <= 1'b0;
      end else begin
         state_q <= state_d;
         ins_ready_q <= state_d == S_RUN || state_d == S_MOV2;
      end
   end

   // Discard of the word(s) after a successful test
   always_ff @(posedge clk) begin
      if (rst) begin
         skip_q <= 1'b0;
      end else if (take && state_q == S_RUN) begin
         if (skip_q) begin
            skip_q <= two_word(ins_word, ext_q);
         end else begin
            skip_q <= op_tst && mrd == RST_BYTE;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         zs_q <= 7'h00;
         indexed_to_indexed_move_op_q <= 1'b0;
      end else if (exec_run && (op_indexed_to_file_move_op || op_indexed_to_indexed_move_op)) begin
         zs_q <= ins_word[6:0];
         indexed_to_indexed_move_op_q <= op_indexed_to_indexed_move_op;
      end
   end

   // Accumulator and flags
   always_ff @(posedge clk) begin
      if (rst) begin
         acc_q <= RST_BYTE;
         status_q <= RST_BYTE;
      end else if (exec_run && (op_literal_exclusive_or_op || op_register_exclusive_or_op)) begin
         if (op_literal_exclusive_or_op || !ins_word[9]) begin
            acc_q <= xor_res;
         end
         status_q[ST_Z] <= xor_res == RST_BYTE;
         status_q[ST_N] <= xor_res[7];
      end else if (reg_we) begin
         if (reg_addr == R_ACC) acc_q <= reg_wdata;
         if (reg_addr == R_STATUS) status_q <= reg_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         bsr_q <= RST_BYTE;
         tlatch_q <= RST_BYTE;
         pc_high_latch_q <= RST_BYTE;
         pc_upper_latch_q <= RST_BYTE;
         dm_addr_q <= '0;
      end else if (reg_we) begin
         if (reg_addr == R_BSR) bsr_q <= reg_wdata;
         if (reg_addr == R_TLATCH) tlatch_q <= reg_wdata;
         if (reg_addr == R_PC_HIGH_LATCH) pc_high_latch_q <= reg_wdata;
         if (reg_addr == R_PC_UPPER_LATCH) pc_upper_latch_q <= reg_wdata;
         if (reg_addr == R_DM_AL) dm_addr_q[7:0] <= reg_wdata;
         if (reg_addr == R_DM_AH) dm_addr_q[DA_W-1:8] <= reg_wdata[DA_W-9:0];
      end
   end

   // Table pointer
   always_comb begin
      tp_next = tp_q;
      if (exec_run && op_table_write_op && ins_word[1:0] == TM_PREINC) begin
         tp_next = tp_q + 21'h00_0001;
      end else if (state_q == S_TBL2 && tmode_q == TM_POSTINC) begin
         tp_next = tp_q + 21'h00_0001;
      end else if (state_q == S_TBL2 && tmode_q == TM_POSTDEC) begin
         tp_next = tp_q - 21'h00_0001;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         tp_q <= '0;
         tmode_q <= TM_KEEP;
      end else begin
         if (exec_run && op_table_write_op) tmode_q <= ins_word[1:0];
         if (reg_we && reg_addr == R_TP_L) begin
            tp_q[7:0] <= reg_wdata;
         end else if (reg_we && reg_addr == R_TP_H) begin
            tp_q[15:8] <= reg_wdata;
         end else if (reg_we && reg_addr == R_TP_U) begin
            tp_q[TP_W-1:16] <= reg_wdata[TP_W-17:0];
         end else begin
            tp_q <= tp_next;
         end
      end
   end

   // File select pointers
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_fsr
         logic sel;
         assign sel = (psel == gi) || (gi == 2 && psel == PSEL_RET);
         always_ff @(posedge clk) begin
            if (rst) begin
               fsr_q[gi] <= '0;
            end else if (exec_run && op_addp && sel) begin
               fsr_q[gi] <= fsr_q[gi] + {6'h00, ins_word[5:0]};
            end else if (exec_run && op_subp && sel) begin
               fsr_q[gi] <= fsr_q[gi] - {6'h00, ins_word[5:0]};
            end else if (exec_run && op_push_literal_op && gi == 2) begin
               fsr_q[gi] <= fsr_q[gi] - 12'h001;
            end else if (reg_we && reg_addr == R_FSR_BASE + 8'(2 * gi)) begin
               fsr_q[gi][7:0] <= reg_wdata;
            end else if (reg_we && reg_addr == R_FSR_BASE + 8'(2 * gi + 1)) begin
               fsr_q[gi][DA_W-1:8] <= reg_wdata[DA_W-9:0];
            end
         end
      end
   endgenerate

   // Call and return strobes
   always_ff @(posedge clk) begin
      if (rst) begin
         stk_push_q <= 1'b0;
         pc_load_q <= 1'b0;
         ret_q <= 1'b0;
         stk_data_q <= '0;
         pc_value_q <= '0;
      end else begin
         stk_push_q <= exec_run && op_accumulator_call_op;
         pc_load_q <= exec_run && op_accumulator_call_op;
         ret_q <= exec_run && op_ptr_ret;
         if (exec_run && op_accumulator_call_op) begin
            stk_data_q <= ins_pc + 21'h00_0002;
            pc_value_q <= {pc_upper_latch_q[TP_W-17:0], pc_high_latch_q, acc_q};
         end
      end
   end

   // Register read port
   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rdata_q <= RST_BYTE;
      end else if (reg_re) begin
         reg_rdata_q <= RST_BYTE;
         if (reg_addr >= R_HOLD_BASE && reg_addr < R_HOLD_BASE + 8'(HOLD_N)) begin
            reg_rdata_q <= hold_rd;
         end
         unique case (reg_addr)
            R_ACC: reg_rdata_q <= acc_q;
            R_STATUS: reg_rdata_q <= status_q;
            R_BSR: reg_rdata_q <= bsr_q;
            R_TLATCH: reg_rdata_q <= tlatch_q;
            R_TP_L: reg_rdata_q <= tp_q[7:0];
            R_TP_H: reg_rdata_q <= tp_q[15:8];
            R_TP_U: reg_rdata_q <= {3'h0, tp_q[TP_W-1:16]};
            R_PC_HIGH_LATCH: reg_rdata_q <= pc_high_latch_q;
            R_PC_UPPER_LATCH: reg_rdata_q <= pc_upper_latch_q;
            R_FSR_BASE: reg_rdata_q <= fsr_q[0][7:0];
            R_FSR_BASE + 8'h01: reg_rdata_q <= {4'h0, fsr_q[0][DA_W-1:8]};
            R_FSR_BASE + 8'h02: reg_rdata_q <= fsr_q[1][7:0];
            R_FSR_BASE + 8'h03: reg_rdata_q <= {4'h0, fsr_q[1][DA_W-1:8]};
            R_FSR_BASE + 8'h04: reg_rdata_q <= fsr_q[2][7:0];
            R_FSR_BASE + 8'h05: reg_rdata_q <= {4'h0, fsr_q[2][DA_W-1:8]};
            R_DM_AL: reg_rdata_q <= dm_addr_q[7:0];
            R_DM_AH: reg_rdata_q <= {4'h0, dm_addr_q[DA_W-1:8]};
            R_DM_DATA: reg_rdata_q <= bus_mrd;
            R_INFO: reg_rdata_q <= {5'h00, state_q != S_RUN, skip_q, ext_q};
            default: ;
         endcase
      end
   end
endmodule

// File: tw_pkg.sv
// Opcode patterns, register map and field positions for the table-write/extension decoder
package tw_pkg;
   localparam int DA_W = 12;
   localparam int TP_W = 21;
   localparam int HOLD_N = 8;
   // Opcode mask/value pairs
   localparam logic [15:0] M_TABLE_WRITE_OP = 16'hFFFC;
   localparam logic [15:0] V_TABLE_WRITE_OP = 16'h000C;
   localparam logic [15:0] M_TST = 16'hFE00;
   localparam logic [15:0] V_TST = 16'h6600;
   localparam logic [15:0] M_LITERAL_EXCLUSIVE_OR_OP = 16'hFF00;
   localparam logic [15:0] V_LITERAL_EXCLUSIVE_OR_OP = 16'h0A00;
   localparam logic [15:0] M_REGISTER_EXCLUSIVE_OR_OP = 16'hFC00;
   localparam logic [15:0] V_REGISTER_EXCLUSIVE_OR_OP = 16'h1800;
   localparam logic [15:0] M_BYTE8 = 16'hFF00;
   localparam logic [15:0] V_ADDP = 16'hE800;
   localparam logic [15:0] V_SUBP = 16'hE900;
   localparam logic [15:0] V_PUSH_LITERAL_OP = 16'hEA00;
   localparam logic [15:0] M_MOVS = 16'hFF80;
   localparam logic [15:0] V_INDEXED_TO_FILE_MOVE_OP = 16'hEB00;
   localparam logic [15:0] V_INDEXED_TO_INDEXED_MOVE_OP = 16'hEB80;
   localparam logic [15:0] V_ACCUMULATOR_CALL_OP = 16'h0014;
   localparam logic [15:0] M_FULL = 16'hFFFF;
   // First words of standard two-word instructions
   localparam logic [15:0] M_CALL2 = 16'hFE00;
   localparam logic [15:0] V_CALL2 = 16'hEC00;
   localparam logic [15:0] M_LFSR2 = 16'hFFC0;
   localparam logic [15:0] V_LFSR2 = 16'hEE00;
   localparam logic [15:0] V_GOTO2 = 16'hEF00;
   localparam logic [15:0] M_NIB = 16'hF000;
   localparam logic [15:0] V_MOVFF2 = 16'hC000;
   // Table pointer modes and pointer select for return
   localparam logic [1:0] TM_KEEP = 2'h0;
   localparam logic [1:0] TM_POSTINC = 2'h1;
   localparam logic [1:0] TM_POSTDEC = 2'h2;
   localparam logic [1:0] TM_PREINC = 2'h3;
   localparam logic [1:0] PSEL_RET = 2'h3;
   // Addressing
   localparam logic [7:0] IDX_LIMIT = 8'h5F;
   localparam logic [7:0] ACC_SPLIT = 8'h80;
   localparam logic [3:0] ACC_HI_BANK = 4'hF;
   // Status bit positions
   localparam int ST_Z = 2;
   localparam int ST_N = 4;
   // Register map (8-bit data)
   localparam logic [7:0] R_ACC = 8'h00;
   localparam logic [7:0] R_STATUS = 8'h01;
   localparam logic [7:0] R_BSR = 8'h02;
   localparam logic [7:0] R_TLATCH = 8'h03;
   localparam logic [7:0] R_TP_L = 8'h04;
   localparam logic [7:0] R_TP_H = 8'h05;
   localparam logic [7:0] R_TP_U = 8'h06;
   localparam logic [7:0] R_PC_HIGH_LATCH = 8'h07;
   localparam logic [7:0] R_PC_UPPER_LATCH = 8'h08;
   localparam logic [7:0] R_FSR_BASE = 8'h09;
   localparam logic [7:0] R_DM_AL = 8'h0F;
   localparam logic [7:0] R_DM_AH = 8'h10;
   localparam logic [7:0] R_DM_DATA = 8'h11;
   localparam logic [7:0] R_INFO = 8'h12;
   localparam logic [7:0] R_HOLD_BASE = 8'h18;
   localparam logic [7:0] RST_BYTE = 8'h00;
endpackage

// File: tw_data_mem.sv
// File register memory with one write port and two read ports
`timescale 1ns/1ps
module tw_data_mem
   import tw_pkg::*;
(
   input wire logic clk,
   input wire logic we,
   input wire logic [DA_W-1:0] waddr,
   input wire logic [7:0] wdata,
   input wire logic [DA_W-1:0] raddr_a,
   output logic [7:0] rdata_a,
   input wire logic [DA_W-1:0] raddr_b,
   output logic [7:0] rdata_b
);
   logic [7:0] mem [0:(1<<DA_W)-1];

   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   assign rdata_a = mem[raddr_a];
   assign rdata_b = mem[raddr_b];
endmodule

// File: tw_hold_regs.sv
// Program-memory write holding registers
`timescale 1ns/1ps
module tw_hold_regs
   import tw_pkg::*;
#(
   parameter int N = HOLD_N
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic we,
   input wire logic [$clog2(N)-1:0] widx,
   input wire logic [7:0] wdata,
   input wire logic [$clog2(N)-1:0] ridx,
   output logic [7:0] rdata
);
   logic [7:0] hold_q [0:N-1];

   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_hold
         always_ff @(posedge clk) begin
            if (rst) begin
               hold_q[i] <= RST_BYTE;
            end else if (we && widx == i) begin
               hold_q[i] <= wdata;
            end
         end
      end
   endgenerate

   assign rdata = hold_q[ridx];
endmodule

// File: tw_decode_monitor.sv
// Port checker for the table-write and extension decoder
`timescale 1ns/1ps
module tw_decode_monitor
   import tw_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic extension_enable_bit,
   input wire logic ins_valid,
   input wire logic [15:0] ins_word,
   input wire logic [TP_W-1:0] ins_pc,
   input wire logic ins_ready_q,
   input wire logic stk_push_q,
   input wire logic [TP_W-1:0] stk_data_q,
   input wire logic pc_load_q,
   input wire logic [TP_W-1:0] pc_value_q,
   input wire logic ret_q,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_we,
   input wire logic reg_re,
   input wire logic [7:0] reg_rdata_q
);
   logic take, tw_take, accumulator_call_op_take, ret_take;
   assign take = ins_valid && ins_ready_q;
   assign tw_take = take && ((ins_word & M_TABLE_WRITE_OP) == V_TABLE_WRITE_OP);
   assign accumulator_call_op_take = take && extension_enable_bit && ins_word == V_ACCUMULATOR_CALL_OP;
   assign ret_take = take && extension_enable_bit && ins_word[15:9] == 7'h74
      && ins_word[7:6] == PSEL_RET;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_ready_after_reset: assert property ($fell(rst) |=> ins_ready_q)
      else $error("decoder not ready after reset");
   a_tw_stall: assert property (tw_take |=> !ins_ready_q)
      else $error("table write did not take a second cycle");
   a_stall_short: assert property (!ins_ready_q |=> ins_ready_q)
      else $error("stall longer than one cycle");
   a_ret_two_cycle: assert property (ret_take |=> ret_q && !ins_ready_q)
      else $error("pointer-and-return missing return or second cycle");
   a_accumulator_call_op_push: assert property (accumulator_call_op_take |=> stk_push_q && pc_load_q && !ins_ready_q
      && stk_data_q == $past(ins_pc) + 21'h2)
      else $error("accumulator call push wrong");
   a_push_load_pair: assert property (stk_push_q |-> pc_load_q)
      else $error("push without program counter load");
   a_ret_single: assert property (ret_q |=> !ret_q)
      else $error("return pulse longer than one cycle");
   a_ext_off_quiet: assert property (!extension_enable_bit |-> !ret_q && !stk_push_q)
      else $error("extended operation while extension off");
   a_rdata_holds: assert property (!reg_re |=> $stable(reg_rdata_q))
      else $error("read data changed without a read");
   c_tw: cover property (tw_take);
   c_accumulator_call_op: cover property (accumulator_call_op_take);
   c_ret: cover property (ret_take);
endmodule
bind tw_decode tw_decode_monitor u_mon (.clk(clk), .rst(rst),
   .extension_enable_bit(extension_enable_bit), .ins_valid(ins_valid), .ins_word(ins_word),
   .ins_pc(ins_pc), .ins_ready_q(ins_ready_q), .stk_push_q(stk_push_q),
   .stk_data_q(stk_data_q), .pc_load_q(pc_load_q), .pc_value_q(pc_value_q), .ret_q(ret_q),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
   .reg_rdata_q(reg_rdata_q));

// File: table_write_and_ext_decode_bench.sv
// Self-checking bench for the table-write and extension decoder
`timescale 1ns/1ps
module table_write_and_ext_decode_bench;
   import tw_pkg::*;
   logic clk = 0, rst = 1, extension_enable_bit = 0, ins_valid = 0, reg_we = 0, reg_re = 0;
   logic [15:0] ins_word = 16'h0000;
   logic [TP_W-1:0] ins_pc = 21'h0_0100, stk_data_q, pc_value_q, sd, pv;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata_q, rv, hi;
   logic ins_ready_q, stk_push_q, pc_load_q, ret_q;
   logic [2:0] pulses;
   int mismatches = 0, check_count = 0, cycles = 0;
   always #4 clk = ~clk;
   tw_decode uut (.clk(clk), .rst(rst), .extension_enable_bit(extension_enable_bit),
      .ins_valid(ins_valid), .ins_word(ins_word), .ins_pc(ins_pc), .ins_ready_q(ins_ready_q),
      .stk_push_q(stk_push_q), .stk_data_q(stk_data_q), .pc_load_q(pc_load_q),
      .pc_value_q(pc_value_q), .ret_q(ret_q), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_we(reg_we), .reg_re(reg_re), .reg_rdata_q(reg_rdata_q));
   task automatic summarize();
      if (mismatches == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         summarize();
      end
   end
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick();
      @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_we <= 1'b1;
      reg_re <= 1'b0;
      ins_valid <= 1'b0;
      tick();
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      reg_addr <= a;
      reg_we <= 1'b0;
      reg_re <= 1'b1;
      ins_valid <= 1'b0;
      tick();
      d = reg_rdata_q;
   endtask
   // Issue one word, capture pulses, then wait out any stall
   task automatic ins(input logic [15:0] w);
      ins_word <= w;
      ins_pc <= ins_pc + 21'h2;
      ins_valid <= 1'b1;
      reg_we <= 1'b0;
      reg_re <= 1'b0;
      while (ins_ready_q !== 1'b1) tick();
      tick();
      pulses = {ret_q, stk_push_q, pc_load_q};
      sd = stk_data_q;
      pv = pc_value_q;
      while (ins_ready_q !== 1'b1) tick();
   endtask
   task automatic do_reset(input logic ext);
      rst <= 1'b1;
      extension_enable_bit <= ext;
      ins_valid <= 1'b0;
      reg_we <= 1'b0;
      reg_re <= 1'b0;
      repeat (5) @(posedge clk);
      #1;
      rst <= 1'b0;
      tick();
   endtask
   task automatic t_ext_off();
      ins(16'hE8A3);
      rd(8'h0D, rv);
      chk(24'(rv), 24'h00);
      ins(V_ACCUMULATOR_CALL_OP);
      chk(24'(pulses), 24'h0);
      rd(R_INFO, rv);
      chk(24'(rv[0]), 24'h0);
      rd(8'h40, rv);
      chk(24'(rv), 24'h00);
   endtask
   task automatic t_table_write();
      logic [20:0] st [4] = '{21'h0_A356, 21'h0_FFFF, 21'h1_0000, 21'h1_389A};
      logic [20:0] e;
      logic [7:0] lo, up;
      for (int m = 0; m < 4; m++) begin
         wr(R_TLATCH, 8'h50 + 8'(m));
         wr(R_TP_L, st[m][7:0]);
         wr(R_TP_H, st[m][15:8]);
         wr(R_TP_U, {3'h0, st[m][20:16]});
         ins(V_TABLE_WRITE_OP | 16'(m));
         e = (m == 1 || m == 3) ? st[m] + 21'h1 : (m == 2) ? st[m] - 21'h1 : st[m];
         rd(R_HOLD_BASE + {5'h0, (m == 3) ? e[2:0] : st[m][2:0]}, rv);
         chk(24'(rv), 24'h50 + 24'(m));
         rd(R_TP_L, lo);
         rd(R_TP_H, hi);
         rd(R_TP_U, up);
         chk({3'h0, up[4:0], hi, lo}, {3'h0, e});
      end
   endtask
   task automatic t_xor();
      wr(R_ACC, 8'hB5);
      ins(16'h0AAF);
      rd(R_ACC, rv);
      chk(24'(rv), 24'h1A);
      ins(16'h0A1A);
      rd(R_STATUS, rv);
      chk(24'(rv & 8'h14), 24'h04);
      ins(16'h0A80);
      rd(R_STATUS, rv);
      chk(24'(rv & 8'h14), 24'h10);
      wr(R_BSR, 8'h03);
      wr(R_DM_AL, 8'h45);
      wr(R_DM_AH, 8'h03);
      wr(R_DM_DATA, 8'hAF);
      wr(R_ACC, 8'hB5);
      ins(16'h1B45);
      rd(R_DM_DATA, rv);
      chk(24'(rv), 24'h1A);
      ins(16'h1945);
      rd(R_ACC, rv);
      chk(24'(rv), 24'hAF);
   endtask
   task automatic t_skip();
      ins(16'h6745);
      ins(16'h0A01);
      wr(R_DM_DATA, 8'h00);
      ins(16'h6745);
      ins(16'h0A01);
      rd(R_ACC, rv);
      chk(24'(rv), 24'hAE);
      ins(16'h6745);
      ins(V_GOTO2);
      ins(16'h0A01);
      ins(16'h0A10);
      rd(R_ACC, rv);
      chk(24'(rv), 24'hBE);
   endtask
   task automatic t_ext_on();
      do_reset(1'b1);
      wr(8'h0D, 8'hFF);
      wr(8'h0E, 8'h03);
      wr(8'h09, 8'h00);
      wr(8'h0A, 8'h01);
      ins(16'hE8A3);
      ins(16'hE93F);
      rd(8'h0D, rv);
      rd(8'h0E, hi);
      chk({8'h0, hi, rv}, 24'h422);
      rd(8'h09, rv);
      rd(8'h0A, hi);
      chk({8'h0, hi, rv}, 24'h0C1);
      ins(16'hE8C1);
      chk(24'(pulses), 24'h4);
      wr(R_ACC, 8'h06);
      wr(R_PC_HIGH_LATCH, 8'h10);
      wr(R_PC_UPPER_LATCH, 8'h00);
      ins(V_ACCUMULATOR_CALL_OP);
      chk({pulses, sd}, {3'h3, ins_pc + 21'h2});
      chk(24'(pv), 24'h1006);
      ins(16'hEA77);
      wr(R_DM_AL, 8'h23);
      wr(R_DM_AH, 8'h04);
      rd(R_DM_DATA, rv);
      chk(24'(rv), 24'h77);
      rd(8'h0D, rv);
      chk(24'(rv), 24'h22);
      // Source 422h plus 45h holds 33h; offset bit 6 set on purpose
      wr(R_DM_AL, 8'h67);
      wr(R_DM_DATA, 8'h33);
      ins(16'hEB45);
      ins(16'hF123);
      ins(16'hEBC5);
      ins(16'hF006);
      wr(R_DM_AL, 8'h28);
      rd(R_DM_DATA, rv);
      chk(24'(rv), 24'h33);
      wr(R_DM_AH, 8'h01);
      wr(R_DM_AL, 8'h23);
      rd(R_DM_DATA, rv);
      chk(24'(rv), 24'h33);
   endtask
   initial begin
      tick();
      do_reset(1'b0);
      t_ext_off();
      t_table_write();
      t_xor();
      t_skip();
      t_ext_on();
      summarize();
   end
endmodule
